/* File: reader_model.sv */
// reader model: carrier field and gap-coded downlink frames
// assumes clk_in only paces field changes off the bench clock edges
module reader_model (
    input wire logic clk_in,
    output logic carrier_out,
    output logic field_out
);
    timeunit 1ns;
    timeprecision 100ps;

    // carrier of 125 ns runs while the field is on, stops low in a gap
    initial begin
        carrier_out = 1'b0;
        field_out = 1'b1;
        #1;
        forever begin
            #62.5;
            carrier_out = field_out ? ~carrier_out : 1'b0;
        end
    end

    // full carrier switch-off for three carrier periods
    task automatic gap;
        @(negedge clk_in);
        field_out = 1'b0;
        #375;
        @(negedge clk_in);
        field_out = 1'b1;
    endtask : gap

    // field stays on for a count of carrier rising edges
    task automatic hold_on(input int n);
        repeat (n) @(posedge carrier_out);
    endtask : hold_on

    // frame of n bits, first bit in bit 37; 12 edges a zero, 36 a one
    task automatic send_frame(input logic [37:0] bits, input int n);
        gap();
        for (int i = 37; i > 37 - n; i--) begin
            hold_on(bits[i] ? 36 : 12);
            gap();
        end
        hold_on(80);
    endtask : send_frame

    // interval far below the shortest valid zero
    task automatic send_short;
        gap();
        hold_on(4);
        gap();
        hold_on(80);
    endtask : send_short
endmodule : reader_model

/* File: rfid_tag_control_logic.sv */
// control core of a passive read/write transponder
// assumes carrier and field-present pins are asynchronous to clk_in
// Overview of operation
// (R1) option register shadows page 1 block 3 and is readable
// (R2) option shadow refreshes during read mode and reloads on any reset
// (R3) configuration register shadows block 0 and is readable
// (R4) configuration shadow refreshes during read and reloads on any reset
// (R5) binary rate selection gives any even divisor from 2 to 128
// (R6) fixed rate selection gives divisors 8,16,32,40,50,64,100,128
// (R7) downlink decoder finds field gaps and validates interval encoding
// (R8) controller decodes commands and flags protocol violations
// (R9) controller governs all memory reads, writes and write protection
// (R10) uplink offers Manchester, bi-phase, FSK, PSK and NRZ encoding
// (R11) all logic is timed by the recovered carrier clock; here every flop runs on clk_in, and the carrier only gives enable ticks
// (R12) reader sends bits as intervals between full carrier gaps
// (R13) uplink bits switch a load across the coil
// (R14) memory holds 11 blocks of 33 bits, accessed whole
// (R15) a set protection bit blocks further writes to its block
// (R16) protection bit is bit 0 and cannot itself be rewritten
// (R17) address 0 always selects page 0 block 0
// (R18) bit-rate strobe fires each time the divisor count is reached
// (R19) invalid downlink is discarded and the tag resumes reading
module rfid_tag_control_logic (
    input wire logic clk_in,
    input wire logic rstn_in,
    input wire logic carrier_field_clock_in,
    input wire logic field_present_in,
    output logic load_mod_out,
    output logic [31:0] config_reg_out,
    output logic [31:0] option_reg_out,
    output logic cmd_error_out,
    output logic write_done_out
);
    // ------------------------------------------------------------------
    // pin synchronisers and edge detection
    // ------------------------------------------------------------------
    logic [1:0] carr_sync;
    logic carr_prev;
    logic [1:0] fld_sync;
    logic fld_prev;
    logic carrier_tick;
    logic gap_start;

    // two flops per pin before any use
    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            carr_sync <= 2'h0;
            carr_prev <= 1'b0;
            fld_sync <= 2'h0;
            fld_prev <= 1'b0;
        end else begin
            carr_sync <= {carr_sync[0], carrier_field_clock_in};
            carr_prev <= carr_sync[1];
            fld_sync <= {fld_sync[0], field_present_in};
            fld_prev <= fld_sync[1];
        end
    end

    assign carrier_tick = carr_sync[1] & ~carr_prev; // R11
    assign gap_start = fld_prev & ~fld_sync[1]; // R12

    // ------------------------------------------------------------------
    // downlink receiver
    // ------------------------------------------------------------------
    tag_pkg::state_type state;
    logic [6:0] interval;
    logic [5:0] nbits;
    logic [37:0] rx_bits;
    logic rx_error;
    logic bit_value;
    logic bit_bad;

    // classify the interval closed by a gap
    always_comb begin
        bit_bad = interval < tag_pkg::ZERO_MIN_FC;
        bit_value = interval >= tag_pkg::ONE_MIN_FC;
    end

    // gap detection and interval decoding
    always_ff @(posedge clk_in) begin
        rx_error <= 1'b0;
        if (!rstn_in) begin
            state <= tag_pkg::ST_READ;
            interval <= 7'h00;
            nbits <= 6'h00;
            rx_bits <= 38'h0;
        end else begin
            case (state)
                tag_pkg::ST_READ: begin
                    if (gap_start) begin
                        state <= tag_pkg::ST_RECEIVE; // R7
                        interval <= 7'h00;
                        nbits <= 6'h00;
                    end
                end
                tag_pkg::ST_RECEIVE: begin
                    if (gap_start) begin
                        interval <= 7'h00;
                        if (bit_bad || nbits == tag_pkg::LEN_WRITE) begin
                            state <= tag_pkg::ST_READ; // R19
                            rx_error <= 1'b1; // R7
                        end else begin
                            rx_bits <= {rx_bits[36:0], bit_value};
                            nbits <= nbits + 6'h01;
                        end
                    end else if (carrier_tick && fld_sync[1]) begin
                        if (interval + 7'h01 >= tag_pkg::END_FC) begin
                            state <= tag_pkg::ST_DECODE;
                        end
                        interval <= interval + 7'h01;
                    end
                end
                tag_pkg::ST_DECODE: begin
                    state <= tag_pkg::ST_READ;
                end
                default: begin
                    state <= tag_pkg::ST_READ;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // command decode
    // ------------------------------------------------------------------
    logic [32:0] mem [tag_pkg::NUM_BLOCKS];
    logic dec_write;
    logic dec_read;
    logic dec_reset;
    logic dec_error;
    logic [3:0] dec_idx;

    // decode a finished stream by its length and opcode
    always_comb begin
        dec_write = 1'b0;
        dec_read = 1'b0;
        dec_reset = 1'b0;
        dec_error = 1'b0;
        dec_idx = tag_pkg::BAD_IDX;
        if (state == tag_pkg::ST_DECODE) begin
            if (nbits == tag_pkg::LEN_WRITE && rx_bits[37]) begin
                dec_idx = tag_pkg::block_index(rx_bits[36], rx_bits[2:0]);
                dec_write = dec_idx != tag_pkg::BAD_IDX
                    && !mem[dec_idx][tag_pkg::LOCK_BIT]; // R15 R16
                dec_error = !dec_write; // R8
            end else if (nbits == tag_pkg::LEN_READ && rx_bits[5]
                         && !rx_bits[3]) begin
                dec_idx = tag_pkg::block_index(rx_bits[4], rx_bits[2:0]);
                dec_read = dec_idx != tag_pkg::BAD_IDX; // R17
                dec_error = !dec_read;
            end else if (nbits == tag_pkg::LEN_RESET
                         && rx_bits[1:0] == tag_pkg::OP_RESET) begin
                dec_reset = 1'b1;
            end else begin
                dec_error = 1'b1; // R8 R19
            end
        end
    end

    // ------------------------------------------------------------------
    // block memory
    // ------------------------------------------------------------------
    // whole-block writes only, data and lock bit together
    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            for (int i = 0; i < tag_pkg::NUM_BLOCKS; i++) begin
                mem[i] <= tag_pkg::USER_RESET;
            end
            mem[tag_pkg::CFG_IDX] <= tag_pkg::CFG_RESET;
            mem[4'h8] <= tag_pkg::TRACE_RESET;
            mem[4'h9] <= tag_pkg::TRACE_RESET;
            mem[tag_pkg::OPT_IDX] <= tag_pkg::OPT_RESET;
        end else if (dec_write) begin
            mem[dec_idx] <= {rx_bits[34:3], rx_bits[35]}; // R9 R14
        end
    end

    // completion and error reporting, a new error wins over the clear
    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            cmd_error_out <= 1'b0;
            write_done_out <= 1'b0;
        end else begin
            write_done_out <= dec_write;
            if (rx_error || dec_error) begin
                cmd_error_out <= 1'b1; // R8
            end else if (gap_start && state == tag_pkg::ST_READ) begin
                cmd_error_out <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // shadow registers
    // ------------------------------------------------------------------
    // follow memory while reading; reload after any reset
    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            config_reg_out <= tag_pkg::CFG_RESET[32:1]; // R4
            option_reg_out <= tag_pkg::OPT_RESET[32:1]; // R2
        end else if (state == tag_pkg::ST_READ || dec_reset) begin
            config_reg_out <= mem[tag_pkg::CFG_IDX][32:1]; // R3 R4
            option_reg_out <= mem[tag_pkg::OPT_IDX][32:1]; // R1 R2
        end
    end

    // ------------------------------------------------------------------
    // uplink sequencing
    // ------------------------------------------------------------------
    logic direct_read;
    logic [3:0] tx_idx;
    logic [4:0] bit_ptr;
    logic bit_strobe;
    logic [2:0] max_blk;
    logic tx_bit;

    assign max_blk = config_reg_out[tag_pkg::CFG_MAXBLK_LSB +: 3];
    assign tx_bit = mem[tx_idx][5'd31 - bit_ptr + 6'd1];

    // walk data bits 32..1 of the selected blocks
    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            direct_read <= 1'b0;
            tx_idx <= 4'h1;
            bit_ptr <= 5'h00;
        end else if (dec_reset) begin
            direct_read <= 1'b0; // R19
            tx_idx <= 4'h1;
            bit_ptr <= 5'h00;
        end else if (dec_read) begin
            direct_read <= 1'b1; // R9
            tx_idx <= dec_idx;
            bit_ptr <= 5'h00;
        end else if (bit_strobe) begin
            bit_ptr <= bit_ptr + 5'h01;
            if (bit_ptr == 5'h1F && !direct_read) begin
                if (tx_idx >= {1'b0, max_blk} || max_blk == 3'h0) begin
                    tx_idx <= 4'h1;
                end else begin
                    tx_idx <= tx_idx + 4'h1;
                end
            end
        end
    end

    uplink_encoder u_enc (
        .clk_in(clk_in),
        .rstn_in(rstn_in),
        .carrier_tick_in(carrier_tick),
        .enable_in(state == tag_pkg::ST_READ && fld_sync[1]), // R19
        .divisor_in(tag_pkg::rate_divisor(config_reg_out)), // R5 R6
        .mod_sel_in(config_reg_out[tag_pkg::CFG_MOD_LSB +: 3]), // R10
        .invert_in(config_reg_out[tag_pkg::CFG_INV_BIT]),
        .bit_in(tx_bit),
        .bit_strobe_out(bit_strobe),
        .load_out(load_mod_out) // R13
    );
endmodule : rfid_tag_control_logic

/* File: rfid_tag_control_logic_checker.sv */
// port checker of the tag control core
// assumes binding to rfid_tag_control_logic in a single clock domain
module rfid_tag_control_logic_checker (
    input wire logic clk_in,
    input wire logic rstn_in,
    input wire logic carrier_field_clock_in,
    input wire logic field_present_in,
    input wire logic load_mod_out,
    input wire logic [31:0] config_reg_out,
    input wire logic [31:0] option_reg_out,
    input wire logic cmd_error_out,
    input wire logic write_done_out
);
    // ------------------------------------------------------------------
    // sequences and properties
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rstn_in);

    // field held off long enough for the decoder to see a gap
    sequence s_gap_held;
        !field_present_in [*8];
    endsequence
    // write completion strobe standing for exactly one cycle
    sequence s_done_pulse;
        write_done_out ##1 !write_done_out;
    endsequence

    property p_cfg_reset;
        $rose(rstn_in) |-> config_reg_out == tag_pkg::CFG_RESET[32:1];
    endproperty
    property p_opt_reset;
        $rose(rstn_in) |-> option_reg_out == tag_pkg::OPT_RESET[32:1];
    endproperty
    property p_out_reset;
        $rose(rstn_in) |-> !load_mod_out && !cmd_error_out && !write_done_out;
    endproperty
    property p_done_pulse;
        write_done_out |-> s_done_pulse;
    endproperty
    property p_done_clean;
        write_done_out |-> !cmd_error_out;
    endproperty
    property p_done_field;
        write_done_out |-> field_present_in && $past(field_present_in, 8);
    endproperty
    property p_cfg_change;
        $changed(config_reg_out) |-> $past(write_done_out);
    endproperty
    property p_opt_change;
        $changed(option_reg_out) |-> $past(write_done_out);
    endproperty
    property p_idle_in_gap;
        s_gap_held |-> !load_mod_out;
    endproperty
    property p_err_clear;
        $fell(cmd_error_out) |-> !field_present_in;
    endproperty

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    a_cfg_reset: assert property (p_cfg_reset)
        else $error("config shadow not at reset value");
    a_opt_reset: assert property (p_opt_reset)
        else $error("option shadow not at reset value");
    a_out_reset: assert property (p_out_reset)
        else $error("outputs active after reset");
    a_done_pulse: assert property (p_done_pulse)
        else $error("write done longer than one cycle");
    a_done_clean: assert property (p_done_clean)
        else $error("write done with error flag");
    a_done_field: assert property (p_done_field)
        else $error("write done without field");
    a_cfg_change: assert property (p_cfg_change)
        else $error("config shadow changed without write");
    a_opt_change: assert property (p_opt_change)
        else $error("option shadow changed without write");
    a_idle_in_gap: assert property (p_idle_in_gap)
        else $error("load switched during a gap");
    a_err_clear: assert property (p_err_clear)
        else $error("error flag cleared outside a gap");
endmodule : rfid_tag_control_logic_checker

bind rfid_tag_control_logic rfid_tag_control_logic_checker u_chk (
    .clk_in(clk_in),
    .rstn_in(rstn_in),
    .carrier_field_clock_in(carrier_field_clock_in),
    .field_present_in(field_present_in),
    .load_mod_out(load_mod_out),
    .config_reg_out(config_reg_out),
    .option_reg_out(option_reg_out),
    .cmd_error_out(cmd_error_out),
    .write_done_out(write_done_out)
);

/* File: tag_pkg.sv */
// constants, field layout and helper functions of the tag control core
// assumes a single 100 MHz system clock; carrier counts are in carrier cycles
package tag_pkg;
    // ------------------------------------------------------------------
    // memory organisation
    // ------------------------------------------------------------------
    localparam int NUM_BLOCKS = 11;
    localparam int BLOCK_W = 33;
    localparam int LOCK_BIT = 0;
    localparam logic [3:0] CFG_IDX = 4'h0; // page 0 block 0
    localparam logic [3:0] OPT_IDX = 4'hA; // page 1 block 3
    localparam logic [3:0] PAGE1_BASE = 4'h7; // page 1 block n at 7 + n
    localparam logic [3:0] BAD_IDX = 4'hF;
    localparam logic [32:0] CFG_RESET = 33'h0_0018_70E0;
    localparam logic [32:0] OPT_RESET = 33'h0_0000_0000;
    localparam logic [32:0] USER_RESET = 33'h0_0000_0000;
    localparam logic [32:0] TRACE_RESET = 33'h0_0000_0001; // arbitrary, locked

    // ------------------------------------------------------------------
    // configuration word fields (data bits 32:1 of block 0)
    // ------------------------------------------------------------------
    localparam int CFG_RATE_LSB = 18; // 6 bits binary, low 3 bits fixed
    localparam int CFG_EXT_BIT = 17; // 1: binary rate selection
    localparam int CFG_MOD_LSB = 12; // 3 bits modulation
    localparam int CFG_MAXBLK_LSB = 5; // 3 bits last block sent
    localparam int CFG_INV_BIT = 4; // inverse data output

    localparam logic [2:0] MOD_NRZ = 3'h0;
    localparam logic [2:0] MOD_PSK = 3'h1;
    localparam logic [2:0] MOD_FSK = 3'h2;
    localparam logic [2:0] MOD_MANCH = 3'h3;
    localparam logic [2:0] MOD_BIPHASE = 3'h4;

    // ------------------------------------------------------------------
    // downlink and FSK subcarrier timing in carrier cycles and command layout
    // ------------------------------------------------------------------
    localparam logic [6:0] ZERO_MIN_FC = 7'h08;
    localparam logic [6:0] ONE_MIN_FC = 7'h20;
    localparam logic [6:0] ONE_MAX_FC = 7'h3F;
    localparam logic [6:0] END_FC = 7'h40;
    localparam logic [2:0] FSK_ZERO_HALF = 3'h4;
    localparam logic [2:0] FSK_ONE_HALF = 3'h5;
    localparam logic [1:0] OP_RESET = 2'h0;
    localparam logic [1:0] OP_PAGE0 = 2'h2;
    localparam logic [1:0] OP_PAGE1 = 2'h3;
    localparam logic [5:0] LEN_RESET = 6'h02;
    localparam logic [5:0] LEN_READ = 6'h06;
    localparam logic [5:0] LEN_WRITE = 6'h26;

    typedef enum logic [1:0] {ST_READ, ST_RECEIVE, ST_DECODE} state_type;

    // carrier divisor from configuration word
    function automatic logic [7:0] rate_divisor(input logic [31:0] cfg);
        logic [5:0] r;
        r = cfg[CFG_RATE_LSB +: 6];
        if (cfg[CFG_EXT_BIT]) begin
            rate_divisor = {1'b0, r, 1'b0} + 8'h02;
        end else begin
            case (r[2:0])
                3'h0: rate_divisor = 8'h08;
                3'h1: rate_divisor = 8'h10;
                3'h2: rate_divisor = 8'h20;
                3'h3: rate_divisor = 8'h28;
                3'h4: rate_divisor = 8'h32;
                3'h5: rate_divisor = 8'h40;
                3'h6: rate_divisor = 8'h64;
                default: rate_divisor = 8'h80;
            endcase
        end
    endfunction : rate_divisor

    // block index from page and address; block 0 ignores the page
    function automatic logic [3:0] block_index(input logic page,
                                               input logic [2:0] addr);
        if (addr == 3'h0) begin
            block_index = CFG_IDX;
        end else if (!page) begin
            block_index = {1'b0, addr};
        end else if (addr <= 3'h3) begin
            block_index = PAGE1_BASE + {1'b0, addr};
        end else begin
            block_index = BAD_IDX;
        end
    endfunction : block_index
endpackage : tag_pkg

/* File: test_rfid_tag_control_logic.sv */
// self-checking bench of the tag control core
// assumes reader_model on the coil side; checker attached by bind
module test_rfid_tag_control_logic;
    timeunit 1ns;
    timeprecision 100ps;

    logic clk_in = 1'b0;
    logic rstn_in = 1'b0;
    logic carrier;
    logic field;
    logic load_mod_out;
    logic cmd_error_out;
    logic write_done_out;
    logic [31:0] config_reg_out;
    logic [31:0] option_reg_out;
    int err_total = 0;
    int total_checks = 0;
    int done_count = 0;
    int carrier_edges = 0;

    // ------------------------------------------------------------------
    // clock, instances and event counters
    // ------------------------------------------------------------------
    always #5 clk_in = ~clk_in;

    reader_model reader (
        .clk_in(clk_in),
        .carrier_out(carrier),
        .field_out(field)
    );

    rfid_tag_control_logic dut (
        .clk_in(clk_in),
        .rstn_in(rstn_in),
        .carrier_field_clock_in(carrier),
        .field_present_in(field),
        .load_mod_out(load_mod_out),
        .config_reg_out(config_reg_out),
        .option_reg_out(option_reg_out),
        .cmd_error_out(cmd_error_out),
        .write_done_out(write_done_out)
    );

    // count write strobes and carrier edges
    always @(posedge clk_in) begin
        if (write_done_out === 1'b1) begin
            done_count++;
        end
    end
    always @(posedge carrier) carrier_edges++;

    // ------------------------------------------------------------------
    // compare, report and transfer tasks
    // ------------------------------------------------------------------
    task automatic check_word(input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected at %0t: exp %h got %h", $time, exp, got);
        end
    endtask : check_word

    task automatic check_bit(input logic exp, input logic got);
        total_checks++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected at %0t: exp %h got %h", $time, exp, got);
        end
    endtask : check_bit

    task automatic tally_and_finish;
        $display("checks %0d errors %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : tally_and_finish

    // write command: opcode 1, page, lock, data, address
    task automatic write_block(input logic page, input logic lock,
                               input logic [31:0] data,
                               input logic [2:0] addr);
        reader.send_frame({1'b1, page, lock, data, addr}, 38);
        repeat (5) @(negedge clk_in);
    endtask : write_block

    // carrier edges between load toggles of alternating nrz data
    task automatic measure_rate(input logic [31:0] exp);
        int start;
        repeat (4) @(load_mod_out);
        repeat (3) begin
            start = carrier_edges;
            @(load_mod_out);
            check_word(exp, 32'(carrier_edges - start));
        end
    endtask : measure_rate

    // ------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------
    task automatic scen_reset_values;
        check_word(tag_pkg::CFG_RESET[32:1], config_reg_out);
        check_word(tag_pkg::OPT_RESET[32:1], option_reg_out);
        check_bit(1'b0, cmd_error_out);
    endtask : scen_reset_values

    // block 1 alternating, then nrz with binary rate 0, max block 1
    task automatic scen_binary_rate;
        write_block(1'b0, 1'b0, 32'hAAAAAAAA, 3'h1);
        write_block(1'b0, 1'b0, 32'h00020020, 3'h0);
        check_word(32'h00000002, 32'(done_count));
        check_word(32'h00020020, config_reg_out);
        measure_rate(32'h00000002);
    endtask : scen_binary_rate

    // page 1 address 0 still lands in block 0; fixed rate index 4
    task automatic scen_fixed_rate;
        write_block(1'b1, 1'b0, 32'h00100020, 3'h0);
        check_word(32'h00100020, config_reg_out);
        measure_rate(32'h00000032);
    endtask : scen_fixed_rate

    // page 1 address 1 is locked: no write, flag raised
    task automatic scen_locked_block;
        int n;
        n = done_count;
        write_block(1'b1, 1'b0, 32'h0000FFFF, 3'h1);
        check_bit(1'b1, cmd_error_out);
        check_word(32'(n), 32'(done_count));
    endtask : scen_locked_block

    // too short an interval: dropped, memory kept, reading resumes
    task automatic scen_bad_interval;
        reader.send_short();
        check_bit(1'b1, cmd_error_out);
        check_word(32'h00100020, config_reg_out);
        measure_rate(32'h00000032);
    endtask : scen_bad_interval

    // option block write clears the flag at frame start
    task automatic scen_option_write;
        write_block(1'b1, 1'b0, 32'h0000A5C3, 3'h3);
        check_bit(1'b0, cmd_error_out);
        check_word(32'h0000A5C3, option_reg_out);
    endtask : scen_option_write

    // direct read of a zero trace block, then reset back to block 1
    task automatic scen_read_reset;
        reader.send_frame({6'h31, 32'h0}, 6);
        repeat (2000) @(negedge clk_in);
        check_bit(1'b0, load_mod_out);
        reader.send_frame(38'h0, 2);
        check_bit(1'b0, cmd_error_out);
        measure_rate(32'h00000032);
    endtask : scen_read_reset

    // ------------------------------------------------------------------
    // main sequence and watchdog
    // ------------------------------------------------------------------
    initial begin
        repeat (5) @(negedge clk_in);
        rstn_in = 1'b1;
        repeat (3) @(negedge clk_in);
        scen_reset_values();
        scen_binary_rate();
        scen_fixed_rate();
        scen_locked_block();
        scen_bad_interval();
        scen_option_write();
        scen_read_reset();
        tally_and_finish();
    end

    // about 80000 cycles expected; cut a hang short well after that
    initial begin
        #1_000_000;
        err_total++;
        tally_and_finish();
    end
endmodule : test_rfid_tag_control_logic

/* File: uplink_encoder.sv */
// bit-rate generator and uplink modulator of the tag
// assumes carrier_tick_in is a one-cycle pulse per carrier cycle
module uplink_encoder (
    input wire logic clk_in,
    input wire logic rstn_in,
    input wire logic carrier_tick_in,
    input wire logic enable_in,
    input wire logic [7:0] divisor_in,
    input wire logic [2:0] mod_sel_in,
    input wire logic invert_in,
    input wire logic bit_in,
    output logic bit_strobe_out,
    output logic load_out
);
    logic [7:0] cnt;
    logic bit_reg;
    logic bp_level;
    logic psk_phase;
    logic [2:0] sub_cnt;
    logic sub_level;
    logic next_load;
    logic phase2;
    logic bit_end;

    assign bit_end = carrier_tick_in && (cnt == divisor_in - 8'h01);
    assign phase2 = cnt >= {1'b0, divisor_in[7:1]};

    // carrier counter, one strobe per bit period
    always_ff @(posedge clk_in) begin
        bit_strobe_out <= 1'b0;
        if (!rstn_in || !enable_in) begin
            cnt <= 8'h00;
        end else if (bit_end) begin
            cnt <= 8'h00; // R18
            bit_strobe_out <= 1'b1; // R5 R6
        end else if (carrier_tick_in) begin
            cnt <= cnt + 8'h01;
        end
    end

    // latch the bit and the bit-boundary phase state
    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            bit_reg <= 1'b0;
            bp_level <= 1'b0;
            psk_phase <= 1'b0;
        end else if (enable_in && bit_end) begin
            bit_reg <= bit_in;
            bp_level <= ~bp_level;
            psk_phase <= psk_phase ^ bit_in;
        end
    end

    // subcarrier for frequency and phase shift keying
    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            sub_cnt <= 3'h0;
            sub_level <= 1'b0;
        end else if (carrier_tick_in) begin
            if (mod_sel_in == tag_pkg::MOD_PSK) begin
                sub_level <= ~sub_level;
                sub_cnt <= 3'h0;
            end else if (sub_cnt + 3'h1 >= (bit_reg ? tag_pkg::FSK_ONE_HALF
                                           : tag_pkg::FSK_ZERO_HALF)) begin
                sub_level <= ~sub_level;
                sub_cnt <= 3'h0;
            end else begin
                sub_cnt <= sub_cnt + 3'h1;
            end
        end
    end

    // encoding select
    always_comb begin
        case (mod_sel_in)
            tag_pkg::MOD_NRZ: next_load = bit_reg;
            tag_pkg::MOD_PSK: next_load = sub_level ^ psk_phase;
            tag_pkg::MOD_FSK: next_load = sub_level;
            tag_pkg::MOD_MANCH: next_load = phase2 ? bit_reg : ~bit_reg;
            tag_pkg::MOD_BIPHASE: next_load = bp_level ^ (phase2 & ~bit_reg);
            default: next_load = bit_reg;
        endcase
    end

    // coil load switch, idle off
    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            load_out <= 1'b0;
        end else begin
            load_out <= enable_in & (next_load ^ invert_in); // R10 R13
        end
    end
endmodule : uplink_encoder
